/* rtl/config_cycle_router.sv */
// routes processor configuration requests to internal, pci express or south link targets
//
// Behaviour
// - index port at io 0cf8, data port at io 0cfc; dword write sets index
// - data port makes configuration cycles only while index bit 31 is set
// - data port accesses the dword chosen by the stored index
// - legacy addressing covers 8 functions and 256 bytes each
// - window gives 4096 bytes per function; upper part only via window
// - window below 4 gb, sized 256, 128 or 64 mb, limiting buses
// - base register bit 0 enables window; firmware sets base via legacy ports
// - window address is base plus bus, device, function and byte offsets
// - memory cycle inside enabled window becomes configuration read or write
// - extended register nibble carried, zero for legacy requests
// - bus 0 to existing enabled internal device is claimed internally
// - header bytes 8 to 11 carry bus, device, function, ext, register
// - bus equal to secondary gives type 0 on pci express
// - type 0 to non-zero device across pci express is master-aborted
// - bus above secondary up to subordinate gives type 1 on pci express
// - window writes post on host bus but wait downstream completion
// - every other configuration bus goes subtractively to the south link; memory cycles outside the window are aborted
// - south link uses type 0 for bus 0, type 1 otherwise
// - unclaimed south link configuration access ends in master abort, except window writes, which are already answered when posted
// - both paths share one internal request format
// - only dword index accesses hit the index; others pass as io
// - bus 0 devices 2 and up go as type 0 to the south link
`timescale 1ns/1ps
module config_cycle_router
    import config_cycle_router_pkg::*;
#(
    parameter int INT_DEVS = 2
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic host_req,
    input wire logic host_io,
    input wire logic host_write,
    input wire logic [31:0] host_addr,
    input wire logic [3:0] host_be,
    input wire logic [31:0] host_wdata,
    output logic host_ready,
    output logic host_done,
    output logic host_abort,
    output logic [31:0] host_rdata,
    input wire logic [31:0] enhanced_window_base,
    input wire logic [7:0] secondary_bus,
    input wire logic [7:0] subordinate_bus,
    input wire logic [INT_DEVS-1:0] internal_dev_enable,
    output logic cfg_write,
    output logic cfg_type1,
    output logic [31:0] cfg_header,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    output logic int_req,
    input wire logic int_done,
    input wire logic [31:0] int_rdata,
    output logic pcie_req,
    input wire logic pcie_done,
    input wire logic pcie_unclaimed,
    input wire logic [31:0] pcie_rdata,
    output logic south_req,
    output logic south_io,
    output logic [15:0] south_io_addr,
    input wire logic south_done,
    input wire logic south_unclaimed,
    input wire logic [31:0] south_rdata
);
    import config_cycle_router_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } state_t;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // request classification
    // ----------------------------------------
    logic [31:0] config_index_port;
    state_t state;
    state_t next_state;
    route_t route;
    route_t next_route;
    logic posted;
    logic accept;
    logic index_hit;
    logic data_hit;
    logic window_hit;
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] func;
    logic [3:0] ext;
    logic [5:0] reg_num;
    logic [31:0] header;
    logic cfg_hit;
    logic south_link_io;
    logic wait_done;
    logic wait_unclaimed;
    logic [31:0] wait_rdata;

    cfg_request_decoder u_decoder (
        .use_window(!host_io),
        .host_addr(host_addr),
        .index(config_index_port),
        .window_base(enhanced_window_base),
        .window_hit(window_hit),
        .bus(bus),
        .dev(dev),
        .func(func),
        .ext(ext),
        .reg_num(reg_num)
    );

    cfg_header_packer u_packer (
        .bus(bus),
        .dev(dev),
        .func(func),
        .ext(ext),
        .reg_num(reg_num),
        .header(header)
    );

    function automatic route_t route_of(input logic [7:0] b, input logic [4:0] d,
                                        input logic [7:0] sec, input logic [7:0] sub,
                                        input logic [INT_DEVS-1:0] en);
        if (b == 8'h00) begin
            if (d < HUB_DEV_COUNT && en[d[0]]) begin
                return ROUTE_INTERNAL;
            end
            return ROUTE_SOUTH;
        end else if (b == sec) begin
            return (d == 5'h00) ? ROUTE_PCIE : ROUTE_ABORT;
        end else if (b > sec && b <= sub) begin
            return ROUTE_PCIE;
        end
        return ROUTE_SOUTH;
    endfunction

    assign accept = host_req && host_ready;
    assign index_hit = host_io && host_addr[15:0] == IO_INDEX_ADDR && host_be == FULL_BE;
    assign data_hit = host_io && host_addr[15:0] == IO_DATA_ADDR && config_index_port[INDEX_ENABLE_BIT];
    assign cfg_hit = data_hit || (!host_io && window_hit);
    assign south_link_io = host_io && !index_hit && !data_hit;

    always_comb begin
        next_route = route;
        if (accept && cfg_hit) begin
            next_route = route_of(bus, dev, secondary_bus, subordinate_bus, internal_dev_enable);
        end else if (accept && south_link_io) begin
            next_route = ROUTE_SOUTH;
        end else if (accept) begin
            next_route = ROUTE_ABORT;
        end
    end

    always_comb begin
        unique case (route)
            ROUTE_INTERNAL: begin
                wait_done = int_done;
                wait_unclaimed = 1'b0;
                wait_rdata = int_rdata;
            end
            ROUTE_PCIE: begin
                wait_done = pcie_done;
                wait_unclaimed = pcie_unclaimed;
                wait_rdata = pcie_rdata;
            end
            ROUTE_SOUTH: begin
                wait_done = south_done;
                wait_unclaimed = south_unclaimed;
                wait_rdata = south_rdata;
            end
            default: begin
                wait_done = 1'b1;
                wait_unclaimed = 1'b1;
                wait_rdata = ABORT_DATA;
            end
        endcase
    end

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (accept && (south_link_io || (cfg_hit && next_route != ROUTE_ABORT))) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_done) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            route <= ROUTE_ABORT;
            host_ready <= 1'b0;
            posted <= 1'b0;
        end else begin
            state <= next_state;
            route <= next_route;
            // stays low while a posted write drains downstream
            host_ready <= next_state == ST_IDLE;
            if (accept) begin
                posted <= !host_io && host_write && cfg_hit;
            end
        end
    end

    // ----------------------------------------
    // index port
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            config_index_port <= INDEX_RESET;
        end else if (accept && index_hit && host_write) begin
            config_index_port <= host_wdata & INDEX_WRITE_MASK;
        end
    end

    // ----------------------------------------
    // downstream request
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_req <= 1'b0;
            pcie_req <= 1'b0;
            south_req <= 1'b0;
            south_io <= 1'b0;
            south_io_addr <= 16'h0000;
            cfg_write <= 1'b0;
            cfg_type1 <= 1'b0;
            cfg_header <= 32'h0000_0000;
            cfg_be <= 4'h0;
            cfg_wdata <= 32'h0000_0000;
        end else begin
            int_req <= 1'b0;
            pcie_req <= 1'b0;
            south_req <= 1'b0;
            if (accept && cfg_hit) begin
                int_req <= next_route == ROUTE_INTERNAL;
                pcie_req <= next_route == ROUTE_PCIE;
                south_req <= next_route == ROUTE_SOUTH;
                south_io <= 1'b0;
                cfg_write <= host_write;
                cfg_type1 <= bus != 8'h00 && bus != secondary_bus;
                cfg_header <= header;
                cfg_be <= host_be;
                cfg_wdata <= host_wdata;
            end else if (accept && south_link_io) begin
                south_req <= 1'b1;
                south_io <= 1'b1;
                south_io_addr <= host_addr[15:0];
                cfg_write <= host_write;
                cfg_type1 <= 1'b0;
                cfg_be <= host_be;
                cfg_wdata <= host_wdata;
            end
        end
    end

    // ----------------------------------------
    // host answer
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_done <= 1'b0;
            host_abort <= 1'b0;
            host_rdata <= 32'h0000_0000;
        end else begin
            host_done <= 1'b0;
            host_abort <= 1'b0;
            if (accept && index_hit) begin
                host_done <= 1'b1;
                host_rdata <= host_write ? 32'h0000_0000 : config_index_port;
            end else if (accept && !south_link_io && !(cfg_hit && next_route != ROUTE_ABORT)) begin
                host_done <= 1'b1;
                host_abort <= 1'b1;
                host_rdata <= host_write ? 32'h0000_0000 : ABORT_DATA;
            end else if (accept && !host_io && host_write && cfg_hit) begin
                host_done <= 1'b1;
                host_rdata <= 32'h0000_0000;
            end else if (state == ST_WAIT && wait_done && !posted) begin
                host_done <= 1'b1;
                host_abort <= wait_unclaimed;
                host_rdata <= (wait_unclaimed || cfg_write) ? (cfg_write ? 32'h0000_0000 : ABORT_DATA) : wait_rdata;
            end
        end
    end
endmodule

/* rtl/config_cycle_router_pkg.sv */
// constants and types shared by the configuration cycle router
package config_cycle_router_pkg;

    // ----------------------------------------
    // legacy i/o port pair
    // ----------------------------------------
    localparam logic [15:0] IO_INDEX_ADDR = 16'h0cf8;
    localparam logic [15:0] IO_DATA_ADDR = 16'h0cfc;
    localparam int INDEX_ENABLE_BIT = 31;
    localparam logic [31:0] INDEX_RESET = 32'h0000_0000;
    // reserved bits 30:24 and 1:0 read as zero
    localparam logic [31:0] INDEX_WRITE_MASK = 32'h80ff_fffc;
    localparam int IDX_REG_LSB = 2;
    localparam int IDX_FUNC_LSB = 8;
    localparam int IDX_DEV_LSB = 11;
    localparam int IDX_BUS_LSB = 16;

    // ----------------------------------------
    // enhanced window base and decode
    // ----------------------------------------
    localparam int BASE_ENABLE_BIT = 0;
    localparam int BASE_SIZE_LSB = 1;
    localparam logic [1:0] SIZE_256MB = 2'h0;
    localparam logic [1:0] SIZE_128MB = 2'h1;
    localparam logic [1:0] SIZE_64MB = 2'h2;
    localparam int WIN_LSB_256MB = 28;
    localparam int WIN_LSB_128MB = 27;
    localparam int WIN_LSB_64MB = 26;
    localparam int MEM_REG_LSB = 2;
    localparam int MEM_EXT_LSB = 8;
    localparam int MEM_FUNC_LSB = 12;
    localparam int MEM_DEV_LSB = 15;
    localparam int MEM_BUS_LSB = 20;

    // ----------------------------------------
    // routing and answers
    // ----------------------------------------
    localparam logic [4:0] HUB_DEV_COUNT = 5'h02;
    localparam logic [3:0] FULL_BE = 4'hf;
    localparam logic [3:0] LEGACY_EXT = 4'h0;
    localparam logic [31:0] ABORT_DATA = 32'hffff_ffff;

    typedef enum logic [3:0] {
        ROUTE_INTERNAL = 4'b0001,
        ROUTE_PCIE = 4'b0010,
        ROUTE_SOUTH = 4'b0100,
        ROUTE_ABORT = 4'b1000
    } route_t;

endpackage

/* rtl/cfg_request_decoder.sv */
// turns either access path into bus, device, function and register fields
`timescale 1ns/1ps
module cfg_request_decoder
    import config_cycle_router_pkg::*;
(
    input wire logic use_window,
    input wire logic [31:0] host_addr,
    input wire logic [31:0] index,
    input wire logic [31:0] window_base,
    output logic window_hit,
    output logic [7:0] bus,
    output logic [4:0] dev,
    output logic [2:0] func,
    output logic [3:0] ext,
    output logic [5:0] reg_num
);
    logic [7:0] win_bus;

    // ----------------------------------------
    // window hit, sized by the base register
    // ----------------------------------------
    always_comb begin
        window_hit = 1'b0;
        win_bus = 8'h00;
        unique case (window_base[BASE_SIZE_LSB +: 2])
            SIZE_256MB: begin
                window_hit = host_addr[31:WIN_LSB_256MB] == window_base[31:WIN_LSB_256MB];
                win_bus = host_addr[MEM_BUS_LSB +: 8];
            end
            SIZE_128MB: begin
                window_hit = host_addr[31:WIN_LSB_128MB] == window_base[31:WIN_LSB_128MB];
                win_bus = {1'b0, host_addr[MEM_BUS_LSB +: 7]};
            end
            SIZE_64MB: begin
                window_hit = host_addr[31:WIN_LSB_64MB] == window_base[31:WIN_LSB_64MB];
                win_bus = {2'b00, host_addr[MEM_BUS_LSB +: 6]};
            end
            default: begin
                window_hit = 1'b0;
                win_bus = 8'h00;
            end
        endcase
        // mechanism is off until firmware sets the enable bit
        window_hit = window_hit & window_base[BASE_ENABLE_BIT];
    end

    // ----------------------------------------
    // one field layout for both paths
    // ----------------------------------------
    always_comb begin
        if (use_window) begin
            bus = win_bus;
            dev = host_addr[MEM_DEV_LSB +: 5];
            func = host_addr[MEM_FUNC_LSB +: 3];
            ext = host_addr[MEM_EXT_LSB +: 4];
            reg_num = host_addr[MEM_REG_LSB +: 6];
        end else begin
            bus = index[IDX_BUS_LSB +: 8];
            dev = index[IDX_DEV_LSB +: 5];
            func = index[IDX_FUNC_LSB +: 3];
            ext = LEGACY_EXT;
            reg_num = index[IDX_REG_LSB +: 6];
        end
    end
endmodule

/* rtl/cfg_header_packer.sv */
// packs request fields into configuration header bytes 8 to 11
`timescale 1ns/1ps
module cfg_header_packer (
    input wire logic [7:0] bus,
    input wire logic [4:0] dev,
    input wire logic [2:0] func,
    input wire logic [3:0] ext,
    input wire logic [5:0] reg_num,
    output logic [31:0] header
);
    // byte 8 sits in the top lane; byte 10 upper nibble reserved
    assign header = {bus, dev, func, 4'h0, ext, reg_num, 2'b00};
endmodule

/* tb/config_cycle_router_assertions.sv */
// port checker for the configuration cycle router
`timescale 1ns/1ps
module config_cycle_router_assertions #(
    parameter int INT_DEVS = 2
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic host_req,
    input wire logic host_io,
    input wire logic host_write,
    input wire logic [31:0] host_addr,
    input wire logic [3:0] host_be,
    input wire logic host_ready,
    input wire logic host_done,
    input wire logic host_abort,
    input wire logic [7:0] secondary_bus,
    input wire logic [7:0] subordinate_bus,
    input wire logic [INT_DEVS-1:0] internal_dev_enable,
    input wire logic cfg_write,
    input wire logic cfg_type1,
    input wire logic [31:0] cfg_header,
    input wire logic int_req,
    input wire logic pcie_req,
    input wire logic south_req,
    input wire logic south_io,
    input wire logic south_done,
    input wire logic south_unclaimed
);
    import config_cycle_router_pkg::*;
    logic last_io, last_write;
    // ----------------------------------------
    // kind of the last accepted host cycle
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_io <= 1'b0;
            last_write <= 1'b0;
        end else if (host_req && host_ready) begin
            last_io <= host_io;
            last_write <= host_write;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_type0_bus;
        pcie_req && !cfg_type1 |-> cfg_header[31:24] == secondary_bus;
    endproperty
    a_type0_bus: assert property (p_type0_bus) else $error("type 0 bus differs from secondary");
    property p_type0_dev;
        pcie_req && !cfg_type1 |-> cfg_header[23:19] == 5'h00;
    endproperty
    a_type0_dev: assert property (p_type0_dev) else $error("type 0 to nonzero device");
    property p_type1_range;
        pcie_req && cfg_type1 |-> cfg_header[31:24] > secondary_bus && cfg_header[31:24] <= subordinate_bus;
    endproperty
    a_type1_range: assert property (p_type1_range) else $error("type 1 bus outside bridge range");
    property p_south_type;
        south_req && !south_io |-> cfg_type1 == (cfg_header[31:24] != 8'h00);
    endproperty
    a_south_type: assert property (p_south_type) else $error("south link type wrong");
    property p_internal;
        int_req |-> cfg_header[31:24] == 8'h00 && cfg_header[23:19] < INT_DEVS && internal_dev_enable[cfg_header[19]];
    endproperty
    a_internal: assert property (p_internal) else $error("internal claim of absent device");
    property p_posted;
        (int_req || pcie_req || south_req) && cfg_write && !last_io |-> host_done && !host_abort;
    endproperty
    a_posted: assert property (p_posted) else $error("window write not posted");
    property p_south_abort;
        south_done && south_unclaimed && !south_io && !last_write |=> host_done && host_abort;
    endproperty
    a_south_abort: assert property (p_south_abort) else $error("unclaimed access not aborted");
    property p_index;
        host_req && host_ready && host_io && host_write && host_addr == 32'(IO_INDEX_ADDR) && host_be == FULL_BE
            |=> host_done && !host_abort && !(int_req || pcie_req || south_req);
    endproperty
    a_index: assert property (p_index) else $error("index write not answered locally");
endmodule
bind config_cycle_router config_cycle_router_assertions #(.INT_DEVS(INT_DEVS)) i_checker (
    .ref_clk, .reset_n, .host_req, .host_io, .host_write, .host_addr, .host_be, .host_ready, .host_done,
    .host_abort, .secondary_bus, .subordinate_bus, .internal_dev_enable, .cfg_write, .cfg_type1,
    .cfg_header, .int_req, .pcie_req, .south_req, .south_io, .south_done, .south_unclaimed
);

/* tb/host_bus_model.sv */
// processor host bus master issuing io and memory cycles
`timescale 1ns/1ps
module host_bus_model (
    input wire logic ref_clk,
    output logic host_req,
    output logic host_io,
    output logic host_write,
    output logic [31:0] host_addr,
    output logic [3:0] host_be,
    output logic [31:0] host_wdata,
    input wire logic host_ready,
    input wire logic host_done,
    input wire logic host_abort,
    input wire logic [31:0] host_rdata
);
    initial begin
        {host_req, host_io, host_write, host_be, host_addr, host_wdata} = 71'h0;
    end
    // no lock qualifier exists on this bus, so no locked cycles are sent
    task automatic cycle(input logic io, input logic wr, input logic [31:0] addr, input logic [3:0] be,
                         input logic [31:0] wd, output logic [31:0] rd, output logic ab, output logic ok);
        int n;
        @(negedge ref_clk);
        host_req = 1'b1;
        host_io = io;
        host_write = wr;
        host_addr = {addr[31:2], 2'h0};
        host_be = be;
        host_wdata = wd;
        n = 0;
        // ready is registered, so its level here holds for the coming edge
        while (host_ready !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        host_req = 1'b0;
        host_addr = ~addr;
        host_wdata = ~wd;
        host_be = ~be;
        n = 0;
        while (host_done !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        rd = host_rdata;
        ab = host_abort;
        ok = host_done;
    endtask
endmodule

/* tb/tb_config_cycle_router.sv */
// self-checking bench for the configuration cycle router
`timescale 1ns/1ps
`define CHK(got, exp, what) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module tb_config_cycle_router;
    import config_cycle_router_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic host_req, host_io, host_write, host_ready, host_done, host_abort;
    logic cfg_write, cfg_type1, int_req, pcie_req, south_req, south_io;
    logic [31:0] host_addr, host_wdata, host_rdata, cfg_header, cfg_wdata, exp_hdr, exp_wdata, resp_data;
    logic [3:0] host_be, cfg_be, exp_be, exp_route;
    logic [15:0] south_io_addr, exp_io_addr;
    logic [31:0] enhanced_window_base = 32'he000_0001;
    logic [31:0] tgt_rdata = 32'h0;
    logic [7:0] secondary_bus = 8'h01;
    logic [7:0] subordinate_bus = 8'h04;
    logic [1:0] internal_dev_enable = 2'h1;
    logic int_done = 1'b0, pcie_done = 1'b0, south_done = 1'b0, tgt_unc = 1'b0;
    logic exp_t1, exp_write, exp_sio, exp_unc;
    logic [31:0] bases [3] = '{32'he000_0001, 32'hc800_0003, 32'h8400_0005};
    int miscompares = 0;
    int total_checks = 0;
    integer seed = 32'haf6f;
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    config_cycle_router #(.INT_DEVS(2)) i_dut (
        .ref_clk, .reset_n, .host_req, .host_io, .host_write, .host_addr, .host_be, .host_wdata,
        .host_ready, .host_done, .host_abort, .host_rdata, .enhanced_window_base, .secondary_bus,
        .subordinate_bus, .internal_dev_enable, .cfg_write, .cfg_type1, .cfg_header, .cfg_be, .cfg_wdata,
        .int_req, .int_done, .int_rdata(tgt_rdata), .pcie_req, .pcie_done, .pcie_unclaimed(tgt_unc),
        .pcie_rdata(tgt_rdata), .south_req, .south_io, .south_io_addr, .south_done,
        .south_unclaimed(tgt_unc), .south_rdata(tgt_rdata)
    );
    host_bus_model i_host (
        .ref_clk, .host_req, .host_io, .host_write, .host_addr, .host_be, .host_wdata,
        .host_ready, .host_done, .host_abort, .host_rdata
    );
    // ----------------------------------------
    // route model and downstream targets
    // ----------------------------------------
    task automatic set_expect(input int bus, input int dev, input int func, input int ext, input int regn);
        exp_hdr = {8'(bus), 5'(dev), 3'(func), 4'h0, 4'(ext), 6'(regn), 2'h0};
        exp_t1 = bus != 0 && bus != secondary_bus;
        exp_sio = 1'b0;
        if (bus == 0) exp_route = (dev < 2 && internal_dev_enable[dev]) ? ROUTE_INTERNAL : ROUTE_SOUTH;
        else if (bus == secondary_bus) exp_route = dev == 0 ? ROUTE_PCIE : ROUTE_ABORT;
        else if (bus > secondary_bus && bus <= subordinate_bus) exp_route = ROUTE_PCIE;
        else exp_route = ROUTE_SOUTH;
    endtask
    initial begin
        int d;
        logic [2:0] hit;
        forever begin
            @(negedge ref_clk);
            hit = {south_req, pcie_req, int_req};
            if (|hit === 1'b1) begin
                `CHK({1'b0, hit}, exp_route, "route")
                `CHK(south_io, exp_sio, "south_io")
                if (exp_sio) `CHK(south_io_addr, exp_io_addr, "south_io_addr")
                else begin
                    `CHK(cfg_header, exp_hdr, "cfg_header")
                    `CHK(cfg_type1, exp_t1, "cfg_type1")
                    `CHK({cfg_write, cfg_be}, {exp_write, exp_be}, "cfg_write_be")
                    if (exp_write) `CHK(cfg_wdata, exp_wdata, "cfg_wdata")
                end
                // slow and prompt answers both occur
                d = {$random(seed)} % 4;
                repeat (d) @(negedge ref_clk);
                tgt_rdata = resp_data;
                tgt_unc = exp_unc;
                {south_done, pcie_done, int_done} = hit;
                @(negedge ref_clk);
                {south_done, pcie_done, int_done} = 3'h0;
                tgt_rdata = ~resp_data;
                tgt_unc = ~exp_unc;
            end
        end
    end
    task automatic op(input logic io, input logic wr, input logic [31:0] addr, input logic [3:0] be,
                      input logic [31:0] wd, input logic [31:0] exp_rd, input logic exp_ab);
        logic [31:0] rd;
        logic ab, ok;
        int n;
        exp_write = wr;
        exp_be = be;
        exp_wdata = wd;
        i_host.cycle(io, wr, addr, be, wd, rd, ab, ok);
        `CHK(ok, 1'b1, "host_done")
        `CHK(ab, exp_ab, "host_abort")
        if (!wr) `CHK(rd, exp_rd, "host_rdata")
        n = 0;
        while (host_ready !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(host_ready, 1'b1, "host_ready")
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        miscompares++;
        end_sim();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int bus, dev, func, ext, regn, sz;
        logic wr, win, ab;
        logic [31:0] addr;
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        {exp_route, exp_unc, exp_sio} = 6'h0;
        op(1'b1, 1'b0, 32'h0cf8, 4'hf, 32'h0, INDEX_RESET, 1'b0);
        {exp_route, exp_sio, exp_io_addr, resp_data} = {ROUTE_SOUTH, 1'b1, IO_DATA_ADDR, 32'h1234_5678};
        op(1'b1, 1'b0, 32'h0cfc, 4'hf, 32'h0, resp_data, 1'b0);
        exp_route = 4'h0;
        op(1'b1, 1'b1, 32'h0cf8, 4'hf, 32'hffff_ffff, 32'h0, 1'b0);
        op(1'b1, 1'b0, 32'h0cf8, 4'hf, 32'h0, INDEX_WRITE_MASK, 1'b0);
        {exp_route, exp_io_addr} = {ROUTE_SOUTH, IO_INDEX_ADDR};
        op(1'b1, 1'b0, 32'h0cf8, 4'h1, 32'h0, resp_data, 1'b0);
        for (int i = 0; i < 60; i++) begin
            sz = i % 3;
            win = (i / 3) % 2;
            wr = 1'($random(seed));
            bus = {$random(seed)} % 256;
            case ({$random(seed)} % 6)
                0: bus = 0;
                1: bus = secondary_bus;
                2: bus = 2 + {$random(seed)} % 3;
                default: ;
            endcase
            dev = ({$random(seed)} % 4 == 0) ? {$random(seed)} % 32 : {$random(seed)} % 2;
            func = {$random(seed)} % 8;
            regn = {$random(seed)} % 64;
            ext = win ? {$random(seed)} % 16 : 0;
            internal_dev_enable = 2'($random(seed));
            exp_unc = ({$random(seed)} % 4) == 0;
            resp_data = $random(seed);
            if (!win) begin
                exp_route = 4'h0;
                op(1'b1, 1'b1, 32'h0cf8, 4'hf, {8'h80, 8'(bus), 5'(dev), 3'(func), 6'(regn), 2'h0},
                   32'h0, 1'b0);
                addr = 32'h0cfc;
            end else begin
                bus = bus % (256 >> sz);
                enhanced_window_base = bases[sz];
                addr = (bases[sz] & (32'hffff_ffff << (28 - sz))) + 32'(bus << 20) + 32'(dev << 15)
                       + 32'(func << 12) + 32'(ext << 8) + 32'(regn << 2);
            end
            set_expect(bus, dev, func, ext, regn);
            ab = exp_route == ROUTE_ABORT || (exp_unc && exp_route != ROUTE_INTERNAL && !(win && wr));
            op(!win, wr, addr, 4'($random(seed)), $random(seed), ab ? ABORT_DATA : resp_data, ab);
        end
        {exp_route, exp_unc} = {ROUTE_ABORT, 1'b0};
        enhanced_window_base = 32'he000_0001;
        op(1'b0, 1'b0, 32'hd000_0000, 4'hf, 32'h0, ABORT_DATA, 1'b1);
        enhanced_window_base = 32'he000_0000;
        op(1'b0, 1'b0, 32'he000_0000, 4'hf, 32'h0, ABORT_DATA, 1'b1);
        end_sim();
    end
endmodule
